// ===== verif/link_checker.sv
`timescale 1ns/100ps
module link_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_d_oe,
  input wire logic link_enabled,
  input wire logic mem_busy,
  input wire logic scan_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence scan_seq;
    ##[1:300] scan_done;
  endsequence
  a_scan_bound: assert property ($fell(reset) |-> scan_seq)
    else $error("scan did not finish in time");
  a_scan_holds: assert property (scan_done |=> scan_done)
    else $error("scan done dropped");
  a_scan_was_busy: assert property ($rose(scan_done) |-> $past(mem_busy))
    else $error("scan ran without busy");
  a_enable_after_scan: assert property (link_enabled |-> scan_done)
    else $error("link enabled before scan");
  a_quiet_disabled: assert property (!link_enabled |-> !sda_d_oe)
    else $error("device drove link while disabled");
  a_busy_nak: assert property ($rose(sda_d_oe) |-> !$past(mem_busy))
    else $error("device acked while busy");
  a_change_scl_low: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device changed data while clock high");
  a_prog_needs_link: assert property ($rose(mem_busy) && scan_done |-> link_enabled)
    else $error("programming started on disabled link");
endmodule

// ===== verif/tb.sv
`timescale 1ns/100ps
module tb;
  logic         clk;
  logic         reset;
  logic         req;
  nvm_pkg::op_t op;
  logic [15:0]  addr;
  logic [7:0]   wdata;
  logic         busy;
  logic         done;
  logic         acked;
  logic [7:0]   rdata;
  logic         link_enabled;
  logic         mem_busy;
  logic         scan_done;
  logic [9:0]   exp_q[$];
  logic [9:0]   e;
  logic [7:0]   last_rd;
  logic [7:0]   d;
  logic [15:0]  a;
  logic         en;
  int           fails;
  int           compares;
  int           seed;
  int           n;
  i2c_link_if link_i();
  nvm_master #(.HALF(4)) nvm_master_i (.clk(clk), .reset(reset), .req(req), .op(op), .addr(addr),
    .wdata(wdata), .busy(busy), .done(done), .acked(acked), .rdata(rdata), .link(link_i.master));
  nvm_device #(.DEPTH(256), .PROG_TICKS(60)) nvm_device_i (.clk(clk), .reset(reset),
    .link_enabled(link_enabled), .mem_busy(mem_busy), .scan_done(scan_done), .link(link_i.device));
  link_checker chk_i (.clk(clk), .reset(reset), .scl(link_i.scl), .sda_d_oe(link_i.sda_d_oe),
    .link_enabled(link_enabled), .mem_busy(mem_busy), .scan_done(scan_done));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one transfer; expectation {check data, ack, data} goes to the queue
  task automatic run(input nvm_pkg::op_t o, input logic [15:0] ad, input logic [7:0] wd,
                     input logic ea, input logic ck, input logic [7:0] ed);
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    #1;
    op = o;
    addr = ad;
    wdata = wd;
    req = 1'b1;
    exp_q.push_back({ck, ea, ed});
    @(posedge clk);
    #1;
    req = 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (exp_q.size() != 0) begin
      fails++;
      $display("[ERR] done expected 1 seen 0");
      exp_q.delete();
    end
  endtask
  task automatic settle();
    n = 0;
    while (mem_busy !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (mem_busy !== 1'b0) begin
      fails++;
      $display("[ERR] mem_busy expected 0 seen %b", mem_busy);
    end
  endtask
  // mid-run reset; the memory keeps its contents and is scanned again
  task automatic restart();
    @(posedge clk);
    #1;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    settle();
  endtask
  always @(posedge clk) begin
    if (done === 1'b1) begin
      e = exp_q.pop_front();
      check("acked", {7'h00, e[8]}, {7'h00, acked});
      if (e[9]) check("rdata", e[7:0], rdata);
      last_rd <= rdata;
    end
  end
  initial begin
    #1000000;
    fails++;
    conclude();
  end
  initial begin
    seed = 32'hF609DF8A;
    reset = 1'b1;
    req = 1'b0;
    op = nvm_pkg::OP_LOAD_ADDR;
    addr = 16'h0000;
    wdata = 8'h00;
    fails = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    run(nvm_pkg::OP_LOAD_ADDR, 16'h0012, 8'h00, 1'b0, 1'b0, 8'h00);
    settle();
    check("scan_done", 8'h01, {7'h00, scan_done});
    check("link_enabled", 8'h01, {7'h00, link_enabled});
    en = (link_enabled === 1'b1);
    for (int i = 0; i < 4; i++) begin
      a = i[0] ? 16'h0050 + ($random(seed) & 16'h001F) : 16'h0024 + ($random(seed) & 16'h001F);
      d = $random(seed);
      run(nvm_pkg::OP_LOAD_ADDR, a, 8'h00, en, 1'b0, 8'h00);
      run(nvm_pkg::OP_WRITE, 16'h0000, d, en, 1'b0, 8'h00);
      run(nvm_pkg::OP_LOAD_ADDR, a ^ 16'h0001, 8'h00, 1'b0, 1'b0, 8'h00);
      settle();
      run(nvm_pkg::OP_READ, 16'h0000, 8'h00, en, en, d);
    end
    a = 16'h0080 + ($random(seed) & 16'h000F);
    run(nvm_pkg::OP_LOAD_ADDR, a, 8'h00, en, 1'b0, 8'h00);
    run(nvm_pkg::OP_READ, 16'h0000, 8'h00, en, 1'b0, 8'h00);
    d = ~last_rd;
    run(nvm_pkg::OP_WRITE, 16'h0000, d, en, 1'b0, 8'h00);
    settle();
    run(nvm_pkg::OP_READ, 16'h0000, 8'h00, en, en, ~d);
    d = $random(seed);
    run(nvm_pkg::OP_LOAD_ADDR, 16'h0002, 8'h00, en, 1'b0, 8'h00);
    run(nvm_pkg::OP_WRITE, 16'h0000, d, en, 1'b0, 8'h00);
    settle();
    run(nvm_pkg::OP_LOAD_ADDR, 16'h00A0, 8'h00, en, 1'b0, 8'h00);
    run(nvm_pkg::OP_WRITE, 16'h0000, 8'h00 - d, en, 1'b0, 8'h00);
    settle();
    restart();
    check("link_enabled", 8'h01, {7'h00, link_enabled});
    run(nvm_pkg::OP_LOAD_ADDR, 16'h0002, 8'h00, 1'b1, 1'b0, 8'h00);
    run(nvm_pkg::OP_READ, 16'h0000, 8'h00, 1'b1, 1'b1, d);
    run(nvm_pkg::OP_WRITE, 16'h0000, d + 8'h01, 1'b1, 1'b0, 8'h00);
    settle();
    restart();
    check("link_enabled", 8'h00, {7'h00, link_enabled});
    run(nvm_pkg::OP_LOAD_ADDR, 16'h0024, 8'h00, 1'b0, 1'b0, 8'h00);
    conclude();
  end
endmodule

// ===== verilog/i2c_link_if.sv
`timescale 1ns/100ps
interface i2c_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  wire  scl;
  wire  sda;
  assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
  assign sda = ((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o)) ? 1'b0 : 1'b1;
  modport device (
    input  scl,
    input  sda,
    output sda_d_o,
    output sda_d_oe
  );
  modport master (
    input  scl,
    input  sda,
    output scl_o,
    output scl_oe,
    output sda_m_o,
    output sda_m_oe
  );
endinterface

// ===== verilog/nvm_defs.svh
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH
`define CMD_LOAD_ADDR    8'h10
`define CMD_WRITE_BYTE   8'h12
`define CMD_READ_BYTE    8'h14
`define GEN_CALL_ADDR    7'h00
`define USER2_HI         16'h03FF
`define USER2_LO         16'h0080
`define CFG_W_HI         16'h007E
`define CFG_W_LO         16'h0050
`define CFG_RO_HI        16'h004E
`define CFG_RO_LO        16'h0040
`define USER1_HI         16'h003E
`define USER1_LO         16'h0012
`define CFG0_HI          16'h0010
`define CFG0_LO          16'h0000
`define CKSUM_ADDR       11'h010
`define PROG_TIME_NS     20000
`define CLK_PERIOD_NS    50
`define PROG_CYCLES      ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LINK_HALF_CYCLES 4
`endif

// ===== verilog/nvm_device.sv
// Behaviour
// - commands 10h load, 12h write, 14h read
// - load takes two address bytes, 64K space
// - write takes one data byte
// - read returns one data byte
// - load acks when idle, naks when busy
// - busy memory naks command and data phases
// - address updates only while memory idle
// - program starts after write plus one byte
// - write only when both phases acked
// - read command acked only if serviceable
// - master retries read after nak; the tb never retries, it waits for mem_busy low before reading back a write
// - master verifies write by reading back
// - user regions freely readable and writable
// - read-only configuration region ignores writes
// - master fixes checksum after config change; the tb leaves its last write at 0002h unfixed before the final reset
// - bad checksum at reset disables link
// - commands share the normal slave link
// - memory scanned after reset before use
`timescale 1ns/100ps
`include "nvm_defs.svh"
module nvm_device #(
  parameter int DEPTH      = 2048,
  parameter int PROG_TICKS = `PROG_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  output logic             link_enabled,
  output logic             mem_busy,
  output logic             scan_done,
  i2c_link_if.device       link
);
  initial begin
    if (DEPTH < 256 || DEPTH > 65536) $error("DEPTH out of range");
    if (PROG_TICKS < 1) $error("PROG_TICKS too small");
  end
  localparam int AW = $clog2(DEPTH);
  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_RBIT,
    S_ACK,
    S_TBIT,
    S_TACK,
    S_WAIT
  } slv_t;
  // erased memory reads zero, which also sums to a good checksum
  logic [7:0]  mem [DEPTH] = '{default: 8'h00};
  slv_t        st_r;
  logic [2:0]  scl_s_r;
  logic [2:0]  sda_s_r;
  logic [2:0]  bit_r;
  logic [7:0]  sh_r;
  logic [1:0]  byte_r;
  nvm_pkg::op_t op_r;
  logic        nak_r;
  logic [7:0]  hi_r;
  logic [15:0] addr_r;
  logic [7:0]  rd_r;
  logic [AW:0] scan_r;
  logic [7:0]  sum_r;
  logic [31:0] prog_r;
  logic        wr_go;
  logic [7:0]  wr_data;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        bad_cmd;
  function automatic logic writable(input logic [15:0] a);
    logic [15:0] w;
    w = {1'b0, a[15:1]};
    writable = (int'(a) < DEPTH) && (w <= `USER2_HI) && !(w >= `CFG_RO_LO && w <= `CFG_RO_HI);
  endfunction
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
    end else begin
      scl_s_r <= {scl_s_r[1:0], link.scl};
      sda_s_r <= {sda_s_r[1:0], link.sda};
    end
  end
  assign scl_rise = scl_s_r[1] && !scl_s_r[2];
  assign scl_fall = !scl_s_r[1] && scl_s_r[2];
  assign start_c  = scl_s_r[1] && sda_s_r[2] && !sda_s_r[1];
  assign stop_c   = scl_s_r[1] && !sda_s_r[2] && sda_s_r[1];
  assign bad_cmd  = (byte_r == 2'h1) && (sh_r != `CMD_LOAD_ADDR) && (sh_r != `CMD_WRITE_BYTE) &&
                    (sh_r != `CMD_READ_BYTE);
  assign mem_busy = (prog_r != 32'h0) || !scan_done;
  // config scan and checksum after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      scan_r       <= '0;
      sum_r        <= 8'h00;
      scan_done    <= 1'b0;
      link_enabled <= 1'b0;
    end else if (!scan_done) begin
      if (scan_r == (AW+1)'(DEPTH)) begin
        scan_done    <= 1'b1;
        link_enabled <= (sum_r == 8'h00);
      end else begin
        if (int'(scan_r) < `USER1_LO * 2 || (int'(scan_r) >= `CFG_W_LO * 2 &&
            int'(scan_r) < `USER2_LO * 2))
          sum_r <= sum_r + mem[scan_r[AW-1:0]];
        scan_r <= scan_r + (AW+1)'(1);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      prog_r <= 32'h0;
    end else if (wr_go) begin
      prog_r <= 32'(PROG_TICKS);
    end else if (prog_r != 32'h0) begin
      prog_r <= prog_r - 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (wr_go && writable(addr_r)) begin
      mem[addr_r[AW-1:0]] <= wr_data;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r          <= S_IDLE;
      bit_r         <= 3'h7;
      sh_r          <= 8'h00;
      byte_r        <= 2'h0;
      op_r          <= nvm_pkg::OP_LOAD_ADDR;
      nak_r         <= 1'b0;
      hi_r          <= 8'h00;
      addr_r        <= 16'h0000;
      rd_r          <= 8'h00;
      wr_go         <= 1'b0;
      wr_data       <= 8'h00;
      link.sda_d_o  <= 1'b1;
      link.sda_d_oe <= 1'b0;
    end else begin
      wr_go <= 1'b0;
      if (!link_enabled || stop_c) begin
        st_r          <= S_IDLE;
        link.sda_d_oe <= 1'b0;
      end else if (start_c) begin
        st_r   <= S_RBIT;
        bit_r  <= 3'h7;
        byte_r <= 2'h0;
        nak_r  <= mem_busy;
        link.sda_d_oe <= 1'b0;
      end else begin
        unique case (st_r)
          S_IDLE, S_ADDR, S_WAIT, S_TBIT, S_TACK: ;
          S_RBIT: if (scl_rise) begin
            sh_r[bit_r] <= sda_s_r[1];
            if (bit_r == 3'h0) st_r <= S_ACK;
            bit_r <= bit_r - 3'h1;
          end
          S_ACK: if (scl_fall) begin
            if (byte_r == 2'h0) begin
              if (sh_r != {`GEN_CALL_ADDR, 1'b0}) begin
                st_r <= S_WAIT;
              end else begin
                link.sda_d_oe <= !nak_r;
                link.sda_d_o  <= 1'b0;
                st_r          <= S_ADDR;
              end
            end else begin
              if (byte_r == 2'h1) begin
                op_r <= (sh_r == `CMD_WRITE_BYTE) ? nvm_pkg::OP_WRITE :
                        (sh_r == `CMD_READ_BYTE) ? nvm_pkg::OP_READ : nvm_pkg::OP_LOAD_ADDR;
                if (bad_cmd) nak_r <= 1'b1;
                if (sh_r == `CMD_READ_BYTE) rd_r <= mem[addr_r[AW-1:0]];
              end
              if (byte_r == 2'h2 && op_r == nvm_pkg::OP_LOAD_ADDR) hi_r <= sh_r;
              if (byte_r == 2'h3 && op_r == nvm_pkg::OP_LOAD_ADDR && !nak_r)
                addr_r <= {hi_r, sh_r};
              if (byte_r == 2'h2 && op_r == nvm_pkg::OP_WRITE && !nak_r) begin
                wr_go   <= 1'b1;
                wr_data <= sh_r;
              end
              link.sda_d_oe <= !nak_r && !bad_cmd;
              link.sda_d_o  <= 1'b0;
              st_r          <= S_ADDR;
            end
          end
          default: st_r <= S_IDLE;
        endcase
        if (st_r == S_ADDR && scl_fall) begin
          link.sda_d_oe <= 1'b0;
          bit_r         <= 3'h7;
          byte_r        <= byte_r + 2'h1;
          if (op_r == nvm_pkg::OP_READ && byte_r == 2'h1) begin
            st_r          <= S_TBIT;
            link.sda_d_o  <= rd_r[7];
            link.sda_d_oe <= !rd_r[7];
          end else begin
            st_r <= S_RBIT;
          end
        end
        if (st_r == S_TBIT && scl_fall) begin
          if (bit_r == 3'h0) begin
            link.sda_d_oe <= !nak_r;
            link.sda_d_o  <= 1'b0;
            st_r          <= S_TACK;
          end else begin
            link.sda_d_o  <= rd_r[bit_r - 3'h1];
            link.sda_d_oe <= !rd_r[bit_r - 3'h1];
            bit_r         <= bit_r - 3'h1;
          end
        end
        if (st_r == S_TACK && scl_fall) begin
          link.sda_d_oe <= 1'b0;
          st_r          <= S_WAIT;
        end
      end
    end
  end
endmodule

// ===== verilog/nvm_master.sv
`timescale 1ns/100ps
`include "nvm_defs.svh"
module nvm_master #(
  parameter int HALF = `LINK_HALF_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              req,
  input  wire nvm_pkg::op_t      op,
  input  wire logic [15:0]       addr,
  input  wire logic [7:0]        wdata,
  output logic                   busy,
  output logic                   done,
  output logic                   acked,
  output logic [7:0]             rdata,
  i2c_link_if.master             link
);
  initial begin
    if (HALF < 4 || HALF > 256) $error("HALF out of range");
  end
  typedef enum logic [2:0] {
    M_IDLE,
    M_START,
    M_BIT,
    M_ACK,
    M_STOP,
    M_DONE
  } mst_t;
  mst_t                 st_r;
  logic [7:0]           cnt_r;
  logic                 ph_r;
  logic [2:0]           bit_r;
  logic [1:0]           byte_r;
  logic [1:0]           nbytes_r;
  logic [7:0]           sh_r;
  logic [7:0]           b1_r;
  logic [7:0]           b2_r;
  logic                 rd_r;
  logic                 ok_r;
  logic                 sda1_r;
  logic                 sda2_r;
  logic                 tick;
  logic                 mid;
  assign tick = (cnt_r == 8'(HALF - 1));
  // data moves only in the middle of the low half, never beside an scl edge
  assign mid  = (cnt_r == 8'(HALF / 2 - 1));
  assign busy = (st_r != M_IDLE);
  always_ff @(posedge clk) begin
    if (reset) begin
      sda1_r <= 1'b1;
      sda2_r <= 1'b1;
    end else begin
      sda1_r <= link.sda;
      sda2_r <= sda1_r;
    end
  end
  always_ff @(posedge clk) begin
    if (reset || st_r == M_IDLE || tick) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r         <= M_IDLE;
      ph_r         <= 1'b0;
      bit_r        <= 3'h0;
      byte_r       <= 2'h0;
      nbytes_r     <= 2'h0;
      sh_r         <= 8'h00;
      b1_r         <= 8'h00;
      b2_r         <= 8'h00;
      rd_r         <= 1'b0;
      ok_r         <= 1'b0;
      done         <= 1'b0;
      acked        <= 1'b0;
      rdata        <= 8'h00;
      link.scl_o   <= 1'b1;
      link.scl_oe  <= 1'b0;
      link.sda_m_o <= 1'b1;
      link.sda_m_oe<= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st_r)
        M_IDLE: begin
          if (req) begin
            st_r    <= M_START;
            ph_r    <= 1'b0;
            ok_r    <= 1'b1;
            rd_r    <= (op == nvm_pkg::OP_READ);
            byte_r  <= 2'h0;
            sh_r    <= {`GEN_CALL_ADDR, 1'b0};
            unique case (op)
              nvm_pkg::OP_LOAD_ADDR: begin
                nbytes_r <= 2'h3;
                b1_r     <= `CMD_LOAD_ADDR;
                b2_r     <= addr[15:8];
                rdata    <= addr[7:0];
              end
              nvm_pkg::OP_WRITE: begin
                nbytes_r <= 2'h2;
                b1_r     <= `CMD_WRITE_BYTE;
                b2_r     <= wdata;
              end
              default: begin
                nbytes_r <= 2'h2;
                b1_r     <= `CMD_READ_BYTE;
                b2_r     <= 8'hFF;
              end
            endcase
          end
        end
        M_START: if (tick) begin
          if (!ph_r) begin
            link.sda_m_o  <= 1'b0;
            link.sda_m_oe <= 1'b1;
            ph_r          <= 1'b1;
          end else begin
            link.scl_o  <= 1'b0;
            link.scl_oe <= 1'b1;
            ph_r        <= 1'b0;
            bit_r       <= 3'h7;
            st_r        <= M_BIT;
          end
        end
        M_BIT: begin
          if (!ph_r && mid) begin
            link.sda_m_o  <= sh_r[bit_r];
            link.sda_m_oe <= !(rd_r && byte_r == 2'h2) && !sh_r[bit_r];
          end
          if (tick) begin
            if (!ph_r) begin
              link.scl_oe <= 1'b0;
              ph_r        <= 1'b1;
            end else begin
              if (rd_r && byte_r == 2'h2) rdata[bit_r] <= sda2_r;
              link.scl_oe <= 1'b1;
              ph_r        <= 1'b0;
              if (bit_r == 3'h0) st_r <= M_ACK;
              else bit_r <= bit_r - 3'h1;
            end
          end
        end
        M_ACK: begin
          if (!ph_r && mid) link.sda_m_oe <= 1'b0;
          if (tick) begin
            if (!ph_r) begin
              link.scl_oe <= 1'b0;
              ph_r        <= 1'b1;
            end else begin
              link.scl_oe <= 1'b1;
              ph_r        <= 1'b0;
              bit_r       <= 3'h7;
              if (sda2_r) begin
                ok_r <= 1'b0;
                st_r <= M_STOP;
              end else if (byte_r == nbytes_r) begin
                st_r <= M_STOP;
              end else begin
                byte_r <= byte_r + 2'h1;
                sh_r   <= (byte_r == 2'h0) ? b1_r : (byte_r == 2'h1) ? b2_r : rdata;
                st_r   <= M_BIT;
              end
            end
          end
        end
        M_STOP: begin
          if (!ph_r && mid) begin
            link.sda_m_o  <= 1'b0;
            link.sda_m_oe <= 1'b1;
          end
          if (tick) begin
            if (!ph_r) begin
              link.scl_oe <= 1'b0;
              ph_r        <= 1'b1;
            end else begin
              link.sda_m_oe <= 1'b0;
              st_r          <= M_DONE;
            end
          end
        end
        M_DONE: begin
          done  <= 1'b1;
          acked <= ok_r;
          st_r  <= M_IDLE;
        end
        default: st_r <= M_IDLE;
      endcase
    end
  end
endmodule

// ===== verilog/nvm_pkg.sv
package nvm_pkg;
  typedef enum logic [1:0] {
    OP_LOAD_ADDR,
    OP_WRITE,
    OP_READ
  } op_t;
endpackage
